// File: hdl/stt_params.svh
// constants of the system tick timer: offsets, fields, resets, timing
`ifndef STT_PARAMS_SVH
`define STT_PARAMS_SVH
`define STT_OFF_CTRL 12'h000
`define STT_OFF_RELOAD 12'h004
`define STT_OFF_CURRENT 12'h008
`define STT_OFF_CALIB 12'h00C
`define STT_BASE_ADDR 32'hE000E010
`define STT_BIT_ENABLE 0
`define STT_BIT_TICKEN 1
`define STT_BIT_CLKSEL 2
`define STT_BIT_WRAP 16
`define STT_BIT_NO_REFERENCE_CLOCK_FLAG 31
`define STT_BIT_INEXACT 30
`define STT_CTRL_RESET 3'h4
`define STT_CALIB_COUNT 24'h002328
`define STT_DIV_RATIO 3'h7
`endif

// File: hdl/stt_pkg.sv
// types of the system tick timer
package stt_pkg;
    typedef struct packed {
        logic [2:0] ctrl;
        logic wrap_seen;
        logic [23:0] reload;
        logic [23:0] count;
        logic [2:0] div;
        logic tick;
        logic [31:0] rdata;
    } stt_state_type;
endpackage

// File: hdl/stt_system_tick.sv
// system tick timer with apb register slave
`timescale 1ns/1ps
`default_nettype none
`include "stt_params.svh"
// What this block does
// - 24-bit down counter, reloads after zero
// - enable loads reload; wrap sets flag, tick
// - wrap flag clears when control is read
// - clock select: 0 divided by 8, 1 core
// - reload copied on enable and on zero
// - flag and tick only on 1 to 0
// - period equals reload plus one
// - current register reads the live count
// - current write clears count and flag
// - calibration bit 31 reads zero
// - calibration bit 30 reads one
// - calibration low bits fixed constant
// - counting stops with gated clock
// - four registers at fixed offsets
// - only privileged accesses reach registers
module stt_system_tick
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [2:0] pprot,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic debug_halt,
    output logic tick_request
);

////////////////////////////////////////////////////////////////////////
stt_pkg::stt_state_type s_q;
stt_pkg::stt_state_type s_d;
logic halt_meta_q;
logic halt_sync_q;
logic access;
logic priv_ok;
logic wr;
logic rd;
logic step;
logic en;

function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a[11:2] == o[11:2]);
endfunction

// debug halt comes from another domain, so it is synchronised first
always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        halt_meta_q <= 1'b0;
        halt_sync_q <= 1'b0;
    end
    else
    begin
        halt_meta_q <= debug_halt;
        halt_sync_q <= halt_meta_q;
    end
end

////////////////////////////////////////////////////////////////////////
assign access = psel && penable;
assign priv_ok = pprot[0];
assign wr = access && pwrite && priv_ok;
assign rd = access && !pwrite && priv_ok;
assign en = s_q.ctrl[`STT_BIT_ENABLE];
// select core rate or one pulse in eight; halt freezes both
assign step = en && !halt_sync_q &&
    (s_q.ctrl[`STT_BIT_CLKSEL] || (s_q.div == `STT_DIV_RATIO));

always_comb
begin
    s_d = s_q;
    s_d.tick = 1'b0;
    s_d.div = s_q.div + 3'h1;
    if (!en)
    begin
        s_d.div = 3'h0;
    end
    // count runs down and reloads from zero
    if (step)
    begin
        if (s_q.count == 24'h000000)
        begin
            s_d.count = s_q.reload;
        end
        else
        begin
            s_d.count = s_q.count - 24'h000001;
            if (s_q.count == 24'h000001)
            begin
                // only a real 1 to 0 step fires
                s_d.wrap_seen = 1'b1;
                s_d.tick = s_q.ctrl[`STT_BIT_TICKEN];
            end
        end
    end
    // reading control clears the flag; a wrap in the same cycle wins
    if (rd && hit(paddr, `STT_OFF_CTRL) && !s_d.tick && !(step &&
        s_q.count == 24'h000001))
    begin
        s_d.wrap_seen = 1'b0;
    end
    if (wr)
    begin
        // reserved bits are dropped on write
        if (hit(paddr, `STT_OFF_CTRL))
        begin
            s_d.ctrl = pwdata[2:0];
            // enable rising loads reload at once
            if (pwdata[`STT_BIT_ENABLE] && !en)
            begin
                s_d.count = s_q.reload;
                s_d.div = 3'h0;
            end
        end
        else if (hit(paddr, `STT_OFF_RELOAD))
        begin
            s_d.reload = pwdata[23:0];
        end
        else if (hit(paddr, `STT_OFF_CURRENT))
        begin
            // any data clears count and flag
            s_d.count = 24'h000000;
            s_d.wrap_seen = 1'b0;
            s_d.tick = 1'b0;
        end
    end
    s_d.rdata = 32'h00000000;
    if (psel && !penable && !pwrite && pprot[0])
    begin
        if (hit(paddr, `STT_OFF_CTRL))
        begin
            s_d.rdata[`STT_BIT_WRAP] = s_q.wrap_seen;
            s_d.rdata[2:0] = s_q.ctrl;
        end
        else if (hit(paddr, `STT_OFF_RELOAD))
        begin
            s_d.rdata[23:0] = s_q.reload;
        end
        else if (hit(paddr, `STT_OFF_CURRENT))
        begin
            s_d.rdata[23:0] = s_d.count;
        end
        else if (hit(paddr, `STT_OFF_CALIB))
        begin
            // fixed calibration word
            s_d.rdata[`STT_BIT_NO_REFERENCE_CLOCK_FLAG] = 1'b0;
            s_d.rdata[`STT_BIT_INEXACT] = 1'b1;
            s_d.rdata[23:0] = `STT_CALIB_COUNT;
        end
    end
end

// pclk gated off means no edges, so the count simply holds
always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        s_q <= '0;
        s_q.ctrl <= `STT_CTRL_RESET;
    end
    else
    begin
        s_q <= s_d;
    end
end

////////////////////////////////////////////////////////////////////////
assign prdata = s_q.rdata;
assign pready = 1'b1;
// unprivileged or unmapped accesses answer with an error
assign pslverr = access && (!priv_ok || paddr[11:4] != 8'h00);
assign tick_request = s_q.tick;

////////////////////////////////////////////////////////////////////////
a_wrap_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (step && s_q.count == 24'h000001 &&
    !(wr && hit(paddr, `STT_OFF_CURRENT))) |=> s_q.wrap_seen)
    else $error("wrap did not set flag");
a_tick_gated_enable: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.tick |-> $past(s_q.ctrl[`STT_BIT_TICKEN]))
    else $error("tick without enable");
a_zero_reloads: assert property (@(posedge pclk) disable iff (!presetn)
    (step && s_q.count == 24'h000000 && !wr) |=> s_q.count == $past(s_q.reload))
    else $error("no reload after zero");
a_no_tick_reload: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.count == 24'h000000 && step) |=> !s_q.tick)
    else $error("tick on reload");
a_halt_freezes: assert property (@(posedge pclk) disable iff (!presetn)
    (halt_sync_q && !wr) |=> $stable(s_q.count))
    else $error("count moved during halt");
a_current_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, `STT_OFF_CURRENT)) |=> s_q.count == 24'h000000 &&
    !s_q.wrap_seen)
    else $error("current write did not clear");
a_div_rate: assert property (@(posedge pclk) disable iff (!presetn)
    (step && !s_q.ctrl[`STT_BIT_CLKSEL]) |=> !step [*7])
    else $error("divided clock too fast");
a_read_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && hit(paddr, `STT_OFF_CTRL) && !(step && s_q.count == 24'h000001))
    |=> !s_q.wrap_seen)
    else $error("flag survived read");
a_calib_word: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && pprot[0] &&
    hit(paddr, `STT_OFF_CALIB)) |=> prdata == {8'h40, `STT_CALIB_COUNT})
    else $error("calibration word wrong");

////////////////////////////////////////////////////////////////////////
// a privileged read in its setup cycle, where prdata is captured
sequence stt_setup_read(logic [11:0] off);
    psel && !penable && !pwrite && pprot[0] && hit(paddr, off);
endsequence

// bus answers
a_unpriv_error: assert property (@(posedge pclk)
    disable iff (!presetn) (access && !pprot[0]) |-> pslverr)
    else $error("unprivileged access not refused");

a_unpriv_no_write: assert property (@(posedge pclk)
    disable iff (!presetn) (access && pwrite && !pprot[0]) |=>
    ($stable(s_q.reload) && $stable(s_q.ctrl)))
    else $error("unprivileged write took effect");

a_unpriv_read_zero: assert property (@(posedge pclk)
    disable iff (!presetn) (psel && !penable && !pwrite && !pprot[0])
    |=> prdata == 32'h00000000)
    else $error("unprivileged read returned data");

a_unmapped_error: assert property (@(posedge pclk)
    disable iff (!presetn) (access && paddr[11:4] != 8'h00) |-> pslverr)
    else $error("unmapped access not refused");

a_mapped_no_error: assert property (@(posedge pclk)
    disable iff (!presetn) (access && pprot[0] && paddr[11:4] == 8'h00)
    |-> !pslverr)
    else $error("mapped access refused");

// register contents
a_ctrl_write: assert property (@(posedge pclk)
    disable iff (!presetn) (wr && hit(paddr, `STT_OFF_CTRL)) |=>
    s_q.ctrl == $past(pwdata[2:0]))
    else $error("control write lost");

a_reload_write: assert property (@(posedge pclk)
    disable iff (!presetn) (wr && hit(paddr, `STT_OFF_RELOAD)) |=>
    s_q.reload == $past(pwdata[23:0]))
    else $error("reload write lost");

a_enable_loads: assert property (@(posedge pclk)
    disable iff (!presetn) (wr && hit(paddr, `STT_OFF_CTRL) &&
    pwdata[`STT_BIT_ENABLE] && !en) |=> s_q.count == $past(s_q.reload))
    else $error("enable did not load reload");

a_calib_read_only: assert property (@(posedge pclk)
    disable iff (!presetn) (wr && hit(paddr, `STT_OFF_CALIB)) |=>
    ($stable(s_q.reload) && $stable(s_q.ctrl)))
    else $error("calibration write changed state");

// read data
a_ctrl_reserved: assert property (@(posedge pclk)
    disable iff (!presetn) stt_setup_read(`STT_OFF_CTRL) |=>
    (prdata[31:17] == 15'h0000 && prdata[15:3] == 13'h0000))
    else $error("control reserved bits not zero");

a_reload_readback: assert property (@(posedge pclk)
    disable iff (!presetn) stt_setup_read(`STT_OFF_RELOAD) |=>
    prdata == {8'h00, $past(s_q.reload)})
    else $error("reload read wrong");

a_current_live: assert property (@(posedge pclk)
    disable iff (!presetn) stt_setup_read(`STT_OFF_CURRENT) |=>
    prdata == {8'h00, s_q.count})
    else $error("current read not live");

a_flag_readback: assert property (@(posedge pclk)
    disable iff (!presetn) stt_setup_read(`STT_OFF_CTRL) |=>
    prdata[`STT_BIT_WRAP] == $past(s_q.wrap_seen))
    else $error("flag read wrong");

// flag and tick
a_flag_sticky: assert property (@(posedge pclk)
    disable iff (!presetn) (s_q.wrap_seen &&
    !(rd && hit(paddr, `STT_OFF_CTRL)) &&
    !(wr && hit(paddr, `STT_OFF_CURRENT))) |=> s_q.wrap_seen)
    else $error("flag lost without read");

a_flag_needs_wrap: assert property (@(posedge pclk)
    disable iff (!presetn) $rose(s_q.wrap_seen) |->
    $past(step && s_q.count == 24'h000001))
    else $error("flag set without wrap");

a_wrap_fires_tick: assert property (@(posedge pclk)
    disable iff (!presetn) (step && s_q.count == 24'h000001 &&
    s_q.ctrl[`STT_BIT_TICKEN] && !(wr && hit(paddr, `STT_OFF_CURRENT)))
    |=> s_q.tick)
    else $error("wrap without tick");

a_tick_one_cycle: assert property (@(posedge pclk)
    disable iff (!presetn) s_q.tick |=> !s_q.tick)
    else $error("tick longer than one cycle");

a_disabled_no_tick: assert property (@(posedge pclk)
    disable iff (!presetn) !en |=> !s_q.tick)
    else $error("tick while disabled");

// counting
a_count_decrements: assert property (@(posedge pclk)
    disable iff (!presetn) (step && s_q.count != 24'h000000 && !wr) |=>
    s_q.count == $past(s_q.count) - 24'h000001)
    else $error("count did not step down");

a_count_holds: assert property (@(posedge pclk)
    disable iff (!presetn) (!step && !wr) |=> $stable(s_q.count))
    else $error("count moved without step");

a_core_rate: assert property (@(posedge pclk)
    disable iff (!presetn) (en && s_q.ctrl[`STT_BIT_CLKSEL] &&
    !halt_sync_q) |-> step)
    else $error("core clock step missing");

a_div_gap: assert property (@(posedge pclk)
    disable iff (!presetn) (en && !s_q.ctrl[`STT_BIT_CLKSEL] &&
    s_q.div != `STT_DIV_RATIO) |-> !step)
    else $error("divided step too early");

a_div_cleared: assert property (@(posedge pclk)
    disable iff (!presetn) !en |=> s_q.div == 3'h0)
    else $error("divider not cleared");

a_halt_no_step: assert property (@(posedge pclk)
    disable iff (!presetn) halt_sync_q |-> !step)
    else $error("step during halt");

endmodule
`default_nettype wire

// File: tb/stt_system_tick_tb.sv
// self-checking bench for the system tick timer
`timescale 1ns/1ps
`default_nettype none
module stt_system_tick_tb;
logic pclk, presetn, psel, penable, pwrite, debug_halt;
logic [11:0] paddr;
logic [31:0] pwdata, prdata, rd, v;
logic [2:0] pprot;
logic pready, pslverr, tick_request, err;
logic [23:0] r;
int miscompares = 0;
int n_checks = 0;
int cyc = 0;
int last = 0;
int per = 0;
int nt = 0;
int n = 0;
stt_system_tick dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pprot(pprot), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .debug_halt(debug_halt), .tick_request(tick_request));
initial
begin
    pclk = 0;
    forever #5 pclk = ~pclk;
end
////////////////////////////////////////////////////////////////////////
// tick spacing in cycles; ceiling cuts a hang
always @(posedge pclk)
begin
    cyc++;
    if (tick_request === 1'b1)
    begin
        per = cyc - last;
        last = cyc;
        nt++;
    end
    if (cyc == 20000)
    begin
        miscompares++;
        complete_run;
    end
end
task automatic complete_run;
    if (miscompares == 0 && n_checks > 0)
        $display("TB: PASS");
    else
        $display("TB: FAIL");
    $finish;
endtask
task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e)
    begin
        miscompares++;
        $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
endtask
// aligned word offsets only
task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask
////////////////////////////////////////////////////////////////////////
initial
begin
    {psel, penable, pwrite, debug_halt} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pprot = 3'h1;
    presetn = 1'b0;
    void'($urandom(38926));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    bus(0, 12'h000, 0); chk("ctrl", rd, 32'h4);
    bus(0, 12'h004, 0); chk("reload", rd, 32'h0);
    bus(0, 12'h008, 0); chk("current", rd, 32'h0);
    bus(0, 12'h00C, 0); chk("calib", rd, 32'h40002328);
    bus(0, 12'h010, 0); chk("unmapped", {rd[31:1], err}, 32'h1);
    v = $urandom & 32'h00FFFFFF;
    bus(1, 12'h004, v);
    bus(0, 12'h004, 0); chk("reload rb", rd, {8'h00, v[23:0]});
    // unprivileged write must leave the reload alone
    pprot <= 3'h0;
    bus(1, 12'h004, 32'h5A); chk("refused", {31'h0, err}, 32'h1);
    pprot <= 3'h1;
    bus(0, 12'h004, 0); chk("kept", rd, {8'h00, v[23:0]});
    for (int k = 1; k >= 0; k--)
    begin
        r = 24'($urandom_range(20, 2));
        bus(1, 12'h004, {8'h00, r});
        bus(1, 12'h008, 0);
        bus(1, 12'h000, k ? 32'h7 : 32'h3);
        repeat (32 * (r + 1)) @(posedge pclk);
        chk("period", per, k ? r + 1 : 8 * (r + 1));
    end
    @(posedge tick_request);
    bus(0, 12'h000, 0); chk("flag set", rd, 32'h10003);
    bus(0, 12'h000, 0); chk("flag clr", rd, 32'h3);
    v = nt;
    bus(1, 12'h000, 32'h1);
    repeat (16 * (r + 1)) @(posedge pclk);
    chk("no tick", nt, v);
    bus(0, 12'h000, 0); chk("flag only", rd, 32'h10001);
    bus(1, 12'h000, 32'h3);
    @(posedge tick_request);
    bus(1, 12'h008, $urandom & 32'h00FFFFFF);
    bus(0, 12'h000, 0); chk("val write", rd, 32'h3);
    debug_halt <= 1'b1;
    repeat (4) @(posedge pclk);
    bus(0, 12'h008, 0);
    v = rd;
    repeat (20) @(posedge pclk);
    bus(0, 12'h008, 0); chk("halt", rd, v);
    debug_halt <= 1'b0;
    // one shot: reload n gives the wrap n steps after enable
    bus(1, 12'h000, 0);
    r = 24'($urandom_range(20, 2));
    bus(1, 12'h004, {8'h00, r});
    bus(1, 12'h000, 32'h7);
    n = 0;
    while (tick_request !== 1'b1 && n < 100)
    begin
        @(posedge pclk);
        n++;
    end
    // registered tick shows one edge after the wrap
    chk("one shot", n, r + 1);
    // reload of zero: counter idles at zero, no wraps
    bus(1, 12'h004, 0);
    bus(1, 12'h008, 0);
    v = nt;
    repeat (100) @(posedge pclk);
    chk("zero", nt, v);
    complete_run;
end
endmodule
`default_nettype wire
